// ---- pic_pkg.sv ----
package pic_pkg;
  // ************************************************************
  // sizes
  // ************************************************************
  localparam int NUM_SRC    = 64;
  localparam int SRC_W      = 6;
  localparam int DATA_W     = 16;
  localparam int ADDR_W     = 5;
  localparam int VBASE_W    = 15;
  localparam int FHIGH_W    = 5;
  localparam int VADDR_W    = 21;
  localparam int NUM_PRIO   = 8;
  // ************************************************************
  // register offsets (word index)
  // ************************************************************
  localparam logic [4:0] OFS_PRIO0  = 5'h00;
  localparam logic [4:0] OFS_VBASE  = 5'h08;
  localparam logic [4:0] OFS_FM0    = 5'h09;
  localparam logic [4:0] OFS_FAL0   = 5'h0A;
  localparam logic [4:0] OFS_FAH0   = 5'h0B;
  localparam logic [4:0] OFS_FM1    = 5'h0C;
  localparam logic [4:0] OFS_FAL1   = 5'h0D;
  localparam logic [4:0] OFS_FAH1   = 5'h0E;
  localparam logic [4:0] OFS_PEND0  = 5'h0F;
  localparam logic [4:0] OFS_CTRL   = 5'h13;
  localparam logic [4:0] OFS_ISTAT  = 5'h14;
  localparam logic [4:0] OFS_IMASK  = 5'h15;
  // ************************************************************
  // fields and reset values
  // ************************************************************
  localparam int CTRL_LVL_LSB  = 0;
  localparam int CTRL_REQ_BIT  = 2;
  localparam int CTRL_FAST_BIT = 3;
  localparam int CTRL_LP_BIT   = 4;
  localparam int EV_REQ        = 0;
  localparam int EV_FAST       = 1;
  localparam int EV_WAKE       = 2;
  localparam int NUM_EV        = 3;
  localparam logic [1:0]  LVL_FAST   = 2'h2;
  localparam logic [1:0]  CODE_OFF   = 2'h0;
  localparam logic [20:0] RESET_ADDR = 21'h000000;
  // sources whose codes map 01..11 to levels 1..3; others map to 0..2
  localparam logic [63:0] HI_RANGE   = 64'h0000_0000_0000_00FF;
  // sources held at level 3 whatever their field says
  localparam logic [63:0] FIXED_TOP  = 64'h0000_0000_0000_0003;
  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic             valid;
    logic [1:0]       level;
    logic [SRC_W-1:0] source;
  } pic_pick_t;

  typedef enum logic [1:0] {
    PIC_SHOW_NONE = 2'b00,
    PIC_SHOW_L0   = 2'b01,
    PIC_SHOW_L1   = 2'b10,
    PIC_SHOW_L23  = 2'b11
  } pic_show_t;
endpackage : pic_pkg

// ---- pic_top.sv ----
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/100ps
`default_nettype none
// Function
// [R1] accept 64 request sources, each assignable to four levels, some fixed; each field here selects one of three (1..3 or 0..2)
// [R2] inside a level the lowest-numbered active source wins
// [R3] signal the core when a request of enough priority waits, with address
// [R4] normal vector address is vector base joined with the source number
// [R5] core masks levels with two status bits; 11 lets only level 3 in
// [R6] control register field shows presented level in two-bit code
// [R7] software makes a fast source: level 2, match register, address pair
// [R8] fast only when the winner matches a match register and is level 2
// [R9] fast requests take their address from the matching address pair
// [R10] core fetches at the vector; a non-subroutine jump means fast handling
// [R11] fast decision is made before the core takes the exception
// [R12] configuration and status reachable as a bus slave
// [R13] in wait or stop, pending requests ask the system to restart clocks
// [R14] after reset the initial fetch address is driven out
// [R15] wake only for requests enabled before low power was entered
// [R16] priority fields reset to 00, which disables the source; here sources 0 and 1 stay enabled at level 3
// [R17] highest active level first, then lowest source within it
module pic_top
(
  input  wire logic                       REF_CLK,
  input  wire logic                       RESET_N,
  input  wire logic                       CLK_EN,
  input  wire logic [pic_pkg::NUM_SRC-1:0] IRQ_IN,
  input  wire logic [1:0]                 CORE_MASK,
  input  wire logic                       LOW_POWER,
  input  wire logic [pic_pkg::ADDR_W-1:0] ADDR,
  input  wire logic [pic_pkg::DATA_W-1:0] WDATA,
  input  wire logic                       WR,
  input  wire logic                       RD,
  output logic      [pic_pkg::DATA_W-1:0] RDATA,
  output logic                            IRQ_REQ,
  output logic      [1:0]                 PRESENTED_LEVEL,
  output logic      [pic_pkg::VADDR_W-1:0] VECTOR_ADDR,
  output logic                            FAST_IRQ,
  output logic                            WAKE_REQ,
  output logic                            INT_OUT
);
  // ************************************************************
  // functions
  // ************************************************************
  function automatic logic [6:0] first_set(input logic [63:0] v);
    logic [6:0] r;
    r = 7'h00;
    for (int i = 63; i >= 0; i--)
    begin
      if (v[i])
      begin
        r = {1'b1, i[5:0]};
      end
    end
    return r;
  endfunction : first_set

  function automatic pic_pkg::pic_show_t show_of(input pic_pkg::pic_pick_t p);
    pic_pkg::pic_show_t s;
    s = pic_pkg::PIC_SHOW_NONE;
    if (p.valid)
    begin
      case (p.level)
        2'h0:    s = pic_pkg::PIC_SHOW_L0;
        2'h1:    s = pic_pkg::PIC_SHOW_L1;
        default: s = pic_pkg::PIC_SHOW_L23;
      endcase
    end
    return s;
  endfunction : show_of

  // ************************************************************
  // registers
  // ************************************************************
  logic [15:0]                   priority_level_regs [pic_pkg::NUM_PRIO];
  logic [pic_pkg::VBASE_W-1:0]   vector_base;
  logic [pic_pkg::SRC_W-1:0]     fast_match_0;
  logic [pic_pkg::SRC_W-1:0]     fast_match_1;
  logic [15:0]                   fast_addr_low_0;
  logic [15:0]                   fast_addr_low_1;
  logic [pic_pkg::FHIGH_W-1:0]   fast_addr_high_0;
  logic [pic_pkg::FHIGH_W-1:0]   fast_addr_high_1;
  logic [pic_pkg::NUM_EV-1:0]    istat;
  logic [pic_pkg::NUM_EV-1:0]    imask;
  logic [pic_pkg::NUM_SRC-1:0]   wake_enable;
  logic                          low_power_q;
  logic [pic_pkg::NUM_SRC-1:0]   enabled;
  logic [pic_pkg::NUM_SRC-1:0]   act [4];
  pic_pkg::pic_pick_t            pick;
  logic                          next_req;
  logic                          next_fast;
  logic [pic_pkg::VADDR_W-1:0]   next_addr;
  logic [pic_pkg::NUM_EV-1:0]    ev;
  logic                          next_wake;
  logic [15:0]                   next_rdata;

  // ************************************************************
  // level sorting
  // ************************************************************
  always_comb
  begin
    logic [1:0] code;
    code = 2'h0;
    for (int l = 0; l < 4; l++)
    begin
      act[l] = '0;
    end
    for (int i = 0; i < pic_pkg::NUM_SRC; i++)
    begin
      code = priority_level_regs[i/8][2*(i%8) +: 2];
      enabled[i] = pic_pkg::FIXED_TOP[i] || (code != pic_pkg::CODE_OFF); // [R16]
      if (IRQ_IN[i])
      begin
        if (pic_pkg::FIXED_TOP[i])
        begin
          act[3][i] = 1'b1; // [R1]
        end
        else if (code != pic_pkg::CODE_OFF)
        begin
          if (pic_pkg::HI_RANGE[i])
          begin
            act[code][i] = 1'b1; // [R1]
          end
          else
          begin
            act[code - 2'h1][i] = 1'b1; // [R1]
          end
        end
      end
    end
  end

  // ************************************************************
  // selection and vector forming
  // ************************************************************
  always_comb
  begin
    logic [6:0] hit;
    hit = 7'h00;
    pick = '0;
    for (int l = 0; l < 4; l++)
    begin
      hit = first_set(act[l]); // [R2]
      if (hit[6])
      begin
        pick.valid = 1'b1; // [R17]
        pick.level = l[1:0];
        pick.source = hit[5:0];
      end
    end
    // the core's own mask is applied here so a masked level never stalls it
    next_req = pick.valid && (pick.level >= CORE_MASK); // [R3] [R5]
    next_fast = 1'b0;
    next_addr = {vector_base, pick.source}; // [R4]
    if (pick.valid && pick.level == pic_pkg::LVL_FAST)
    begin
      if (pick.source == fast_match_0)
      begin
        next_fast = 1'b1; // [R8]
        next_addr = {fast_addr_high_0, fast_addr_low_0}; // [R9]
      end
      else if (pick.source == fast_match_1)
      begin
        next_fast = 1'b1; // [R8]
        next_addr = {fast_addr_high_1, fast_addr_low_1}; // [R9]
      end
    end
  end

  // decision registered with the request, so the address is ready first
  always_ff @(posedge REF_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      IRQ_REQ <= 1'b0;
      PRESENTED_LEVEL <= pic_pkg::PIC_SHOW_NONE;
      FAST_IRQ <= 1'b0;
      VECTOR_ADDR <= pic_pkg::RESET_ADDR; // [R14]
    end
    else if (CLK_EN)
    begin
      IRQ_REQ <= next_req; // [R3]
      PRESENTED_LEVEL <= show_of(pick); // [R6]
      FAST_IRQ <= next_req && next_fast; // [R11]
      if (next_req)
      begin
        VECTOR_ADDR <= next_addr; // [R11]
      end
    end
  end

  // ************************************************************
  // low power wake
  // ************************************************************
  assign next_wake = low_power_q && |(IRQ_IN & wake_enable); // [R13] [R15]

  always_ff @(posedge REF_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      low_power_q <= 1'b0;
      wake_enable <= '0;
      WAKE_REQ <= 1'b0;
    end
    else if (CLK_EN)
    begin
      low_power_q <= LOW_POWER;
      if (LOW_POWER && !low_power_q)
      begin
        wake_enable <= enabled; // [R15]
      end
      WAKE_REQ <= next_wake; // [R13]
    end
  end

  // ************************************************************
  // register writes
  // ************************************************************
  always_ff @(posedge REF_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      for (int k = 0; k < pic_pkg::NUM_PRIO; k++)
      begin
        priority_level_regs[k] <= 16'h0000; // [R16]
      end
      vector_base <= '0;
      fast_match_0 <= '0;
      fast_match_1 <= '0;
      fast_addr_low_0 <= 16'h0000;
      fast_addr_low_1 <= 16'h0000;
      fast_addr_high_0 <= '0;
      fast_addr_high_1 <= '0;
      imask <= '0;
    end
    else if (CLK_EN && WR)
    begin
      if (ADDR < pic_pkg::OFS_VBASE)
      begin
        priority_level_regs[ADDR[2:0]] <= WDATA; // [R12]
      end
      case (ADDR)
        pic_pkg::OFS_VBASE: vector_base <= WDATA[pic_pkg::VBASE_W-1:0];
        pic_pkg::OFS_FM0:   fast_match_0 <= WDATA[pic_pkg::SRC_W-1:0];
        pic_pkg::OFS_FAL0:  fast_addr_low_0 <= WDATA;
        pic_pkg::OFS_FAH0:  fast_addr_high_0 <= WDATA[pic_pkg::FHIGH_W-1:0];
        pic_pkg::OFS_FM1:   fast_match_1 <= WDATA[pic_pkg::SRC_W-1:0];
        pic_pkg::OFS_FAL1:  fast_addr_low_1 <= WDATA;
        pic_pkg::OFS_FAH1:  fast_addr_high_1 <= WDATA[pic_pkg::FHIGH_W-1:0];
        pic_pkg::OFS_IMASK: imask <= WDATA[pic_pkg::NUM_EV-1:0];
        default:            ;
      endcase
    end
  end

  // ************************************************************
  // event status and interrupt line
  // ************************************************************
  assign ev = {next_wake && !WAKE_REQ,
               next_req && next_fast && !FAST_IRQ,
               next_req && !IRQ_REQ};

  always_ff @(posedge REF_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      istat <= '0;
      INT_OUT <= 1'b0;
    end
    else if (CLK_EN)
    begin
      // a new event in the clearing read still lands
      if (RD && ADDR == pic_pkg::OFS_ISTAT)
      begin
        istat <= ev;
      end
      else
      begin
        istat <= istat | ev;
      end
      INT_OUT <= |(istat & imask);
    end
  end

  // ************************************************************
  // register reads
  // ************************************************************
  always_comb
  begin
    next_rdata = 16'h0000;
    if (ADDR < pic_pkg::OFS_VBASE)
    begin
      next_rdata = priority_level_regs[ADDR[2:0]];
    end
    case (ADDR)
      pic_pkg::OFS_VBASE: next_rdata = 16'(vector_base);
      pic_pkg::OFS_FM0:   next_rdata = 16'(fast_match_0);
      pic_pkg::OFS_FAL0:  next_rdata = fast_addr_low_0;
      pic_pkg::OFS_FAH0:  next_rdata = 16'(fast_addr_high_0);
      pic_pkg::OFS_FM1:   next_rdata = 16'(fast_match_1);
      pic_pkg::OFS_FAL1:  next_rdata = fast_addr_low_1;
      pic_pkg::OFS_FAH1:  next_rdata = 16'(fast_addr_high_1);
      5'h0F:              next_rdata = IRQ_IN[15:0];
      5'h10:              next_rdata = IRQ_IN[31:16];
      5'h11:              next_rdata = IRQ_IN[47:32];
      5'h12:              next_rdata = IRQ_IN[63:48];
      pic_pkg::OFS_CTRL:
      begin
        next_rdata[pic_pkg::CTRL_LVL_LSB +: 2] = PRESENTED_LEVEL; // [R6]
        next_rdata[pic_pkg::CTRL_REQ_BIT] = IRQ_REQ;
        next_rdata[pic_pkg::CTRL_FAST_BIT] = FAST_IRQ;
        next_rdata[pic_pkg::CTRL_LP_BIT] = low_power_q;
      end
      pic_pkg::OFS_ISTAT: next_rdata = 16'(istat);
      pic_pkg::OFS_IMASK: next_rdata = 16'(imask);
      default:            ;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      RDATA <= 16'h0000;
    end
    else if (CLK_EN)
    begin
      RDATA <= RD ? next_rdata : 16'h0000; // [R12]
    end
  end
endmodule : pic_top
`default_nettype wire

// ---- pic_checker.sv ----
`timescale 1ns/100ps
`default_nettype none
module pic_checker
(
  input wire logic        REF_CLK,
  input wire logic        RESET_N,
  input wire logic [63:0] IRQ_IN,
  input wire logic        LOW_POWER,
  input wire logic [4:0]  ADDR,
  input wire logic        RD,
  input wire logic [15:0] RDATA,
  input wire logic        IRQ_REQ,
  input wire logic [1:0]  PRESENTED_LEVEL,
  input wire logic [20:0] VECTOR_ADDR,
  input wire logic        FAST_IRQ,
  input wire logic        WAKE_REQ
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);
  // ************
  // sequences
  // ************
  sequence hole_read;
    RD && ADDR > 5'h15 ##1 1'b1;
  endsequence
  // ************
  // properties
  // ************
  chk_rd_idle:
    assert property (!$past(RD) |-> RDATA == 16'h0000)
    else $error("read data outside its slot");
  chk_rd_hole:
    assert property (hole_read |-> RDATA == 16'h0000)
    else $error("unmapped read not zero");
  chk_req_cause:
    assert property ($rose(IRQ_REQ) |-> $past(|IRQ_IN))
    else $error("request with no source");
  chk_no_src:
    assert property (IRQ_IN == 64'h0 |=> !IRQ_REQ && !FAST_IRQ)
    else $error("request stayed without source");
  chk_req_level:
    assert property (IRQ_REQ |-> PRESENTED_LEVEL != 2'h0)
    else $error("request shown with empty level");
  chk_fast_level:
    assert property (FAST_IRQ |-> PRESENTED_LEVEL == 2'h3)
    else $error("fast request not at level two");
  chk_wake_lp:
    assert property ($rose(WAKE_REQ) |-> $past(LOW_POWER, 2))
    else $error("wake outside low power");
  chk_vec_hold:
    assert property (PRESENTED_LEVEL == 2'h0 |-> $stable(VECTOR_ADDR))
    else $error("vector moved with no request");
endmodule : pic_checker

bind pic_top pic_checker u_chk
(
  .REF_CLK(REF_CLK),
  .RESET_N(RESET_N),
  .IRQ_IN(IRQ_IN),
  .LOW_POWER(LOW_POWER),
  .ADDR(ADDR),
  .RD(RD),
  .RDATA(RDATA),
  .IRQ_REQ(IRQ_REQ),
  .PRESENTED_LEVEL(PRESENTED_LEVEL),
  .VECTOR_ADDR(VECTOR_ADDR),
  .FAST_IRQ(FAST_IRQ),
  .WAKE_REQ(WAKE_REQ)
);
`default_nettype wire

// ---- pic_core_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module pic_core_model
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [1:0]  want_mask,
  input  wire logic        sleep,
  input  wire logic        irq_req,
  input  wire logic [20:0] vector_addr,
  output logic      [1:0]  core_mask,
  output logic             low_power,
  output logic      [20:0] fetch_addr
);
  // ************
  // core side
  // ************
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      core_mask  <= 2'h0;
      low_power  <= 1'b0;
      fetch_addr <= 21'h000000;
    end
    else
    begin
      core_mask <= want_mask;
      low_power <= sleep;
      // no fetch while asleep: the clocks would be stopped
      if (irq_req && !sleep)
        fetch_addr <= vector_addr;
    end
endmodule : pic_core_model
`default_nettype wire

// ---- pic_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module pic_tb_top;
  localparam logic [14:0] VB = 15'h2ACE;
  logic        ref_clk   = 1'b0;
  logic        reset_n   = 1'b0;
  logic [63:0] irq_in    = 64'h0;
  logic [4:0]  addr      = 5'h00;
  logic [15:0] wdata     = 16'h0000;
  logic        wr        = 1'b0;
  logic        rd        = 1'b0;
  logic [1:0]  want_mask = 2'h0;
  logic        sleep     = 1'b0;
  logic        clk_en    = 1'b1;
  logic [1:0]  core_mask;
  logic        low_power;
  logic [20:0] fetch_addr;
  logic [15:0] rdata;
  logic        irq_req;
  logic        fast_irq;
  logic        wake_req;
  logic        int_out;
  logic [1:0]  lvl;
  logic [20:0] vaddr;
  int          failures  = 0;
  int          checked   = 0;
  wire logic [24:0] got = {irq_req, lvl, fast_irq, vaddr};
  always #2.5 ref_clk = ~ref_clk;
  pic_top u_dut
  (
    .REF_CLK(ref_clk),
    .RESET_N(reset_n),
    .CLK_EN(clk_en),
    .IRQ_IN(irq_in),
    .CORE_MASK(core_mask),
    .LOW_POWER(low_power),
    .ADDR(addr),
    .WDATA(wdata),
    .WR(wr),
    .RD(rd),
    .RDATA(rdata),
    .IRQ_REQ(irq_req),
    .PRESENTED_LEVEL(lvl),
    .VECTOR_ADDR(vaddr),
    .FAST_IRQ(fast_irq),
    .WAKE_REQ(wake_req),
    .INT_OUT(int_out)
  );
  pic_core_model u_core
  (
    .clk(ref_clk),
    .rst_n(reset_n),
    .want_mask(want_mask),
    .sleep(sleep),
    .irq_req(irq_req),
    .vector_addr(vaddr),
    .core_mask(core_mask),
    .low_power(low_power),
    .fetch_addr(fetch_addr)
  );
  // ************
  // tasks
  // ************
  task automatic check(input logic [24:0] seen, input logic [24:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic wreg(input logic [4:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr    <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [4:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd   <= 1'b0;
    #1 check(25'(rdata), 25'(exp));
  endtask : rreg
  // set the sources, then let the registered outputs land
  task automatic fire(input logic [63:0] v);
    @(posedge ref_clk);
    irq_in <= v;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : fire
  task automatic final_report();
    $display("compares %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  // ************
  // sequence
  // ************
  initial
  begin
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    fire(64'h0);
    check(25'(vaddr), 25'(pic_pkg::RESET_ADDR));
    rreg(pic_pkg::OFS_PRIO0, 16'h0000);
    rreg(5'h1F, 16'h0000);
    wreg(pic_pkg::OFS_VBASE, {1'b0, VB});
    rreg(pic_pkg::OFS_VBASE, {1'b0, VB});
    // a write while the clock enable is low must not land
    @(posedge ref_clk);
    clk_en <= 1'b0;
    wreg(pic_pkg::OFS_VBASE, 16'h0055);
    clk_en <= 1'b1;
    rreg(pic_pkg::OFS_VBASE, {1'b0, VB});
    wreg(5'h02, 16'h0100);
    wreg(5'h01, 16'h0010);
    wreg(5'h03, 16'h3000);
    fire(64'h1 << 20);
    check(got, {1'b1, 2'h1, 1'b0, VB, 6'h14});
    check(25'(int_out), 25'h0);
    wreg(pic_pkg::OFS_IMASK, 16'h0001);
    fire(64'h1 << 20 | 64'h1 << 10);
    check(got, {1'b1, 2'h1, 1'b0, VB, 6'h0A});
    check(25'(int_out), 25'h1);
    rreg(pic_pkg::OFS_ISTAT, 16'h0001);
    fire(64'h1 << 20 | 64'h1 << 10 | 64'h1 << 30);
    check(got, {1'b1, 2'h3, 1'b0, VB, 6'h1E});
    check(25'(int_out), 25'h0);
    wreg(pic_pkg::OFS_FM0, 16'h001E);
    wreg(pic_pkg::OFS_FAL0, 16'h1234);
    wreg(pic_pkg::OFS_FAH0, 16'h000A);
    fire(irq_in);
    check(got, {1'b1, 2'h3, 1'b1, 5'h0A, 16'h1234});
    check(25'(fetch_addr), 25'({5'h0A, 16'h1234}));
    rreg(pic_pkg::OFS_CTRL, 16'h000F);
    wreg(pic_pkg::OFS_FM1, 16'h0003);
    wreg(pic_pkg::OFS_PRIO0, 16'h00C0);
    fire(irq_in | 64'h8);
    check(got, {1'b1, 2'h3, 1'b0, VB, 6'h03});
    rreg(pic_pkg::OFS_PEND0, 16'h0408);
    rreg(5'h10, 16'h4010);
    // second match pair alone decides, first pair points elsewhere
    wreg(pic_pkg::OFS_FM0, 16'h003F);
    wreg(pic_pkg::OFS_FM1, 16'h001E);
    wreg(pic_pkg::OFS_FAL1, 16'h5678);
    wreg(pic_pkg::OFS_FAH1, 16'h0015);
    fire(64'h1 << 30);
    check(got, {1'b1, 2'h3, 1'b1, 5'h15, 16'h5678});
    rreg(pic_pkg::OFS_FAL1, 16'h5678);
    for (int m = 0; m < 4; m++)
    begin
      want_mask <= 2'(m);
      fire(64'h1 << 20);
      check(25'(irq_req), 25'(m == 0));
      fire(64'h1 << 30);
      check(25'(irq_req), 25'(m != 3));
    end
    want_mask <= 2'h0;
    fire(64'h1);
    check(got, {1'b1, 2'h3, 1'b0, VB, 6'h00});
    fire(64'h1 << 50);
    check(25'(irq_req), 25'h0);
    fire(64'h0);
    sleep <= 1'b1;
    wreg(5'h06, 16'h0010);
    fire(64'h1 << 50);
    repeat (4) @(posedge ref_clk);
    #1 check(25'(wake_req), 25'h0);
    fire(64'h1 << 20);
    for (int i = 0; i < 10 && wake_req !== 1'b1; i++)
      @(posedge ref_clk);
    #1 check(25'(wake_req), 25'h1);
    rreg(pic_pkg::OFS_ISTAT, 16'h0007);
    final_report();
  end
endmodule : pic_tb_top
`default_nettype wire
